// file: bus_pkg.sv
// Shared constants and types for the backplane bus ends
package bus_pkg;
	localparam int ADR_W = 24;
	localparam int DAT_W = 16;
	localparam int CTL_W = 10;
	localparam int INT_W = 8;
	localparam int LVL_W = 3;
	// Control line positions within the ctl vector
	localparam int C_BUSY = 0;
	localparam int C_MRDC = 1;
	localparam int C_MWTC = 2;
	localparam int C_IORC = 3;
	localparam int C_IOWC = 4;
	localparam int C_XACK = 5;
	localparam int C_INH1 = 6;
	localparam int C_INH2 = 7;
	localparam int C_LOCK = 8;
	localparam int C_BHEN = 9;
	// Slave windows of the device end
	localparam logic [ADR_W-1:0] RAM_BASE = 24'h01_0000;
	localparam int RAM_LSB = 5;
	localparam int RAM_WORDS = 16;
	localparam logic [ADR_W-1:0] ROM_BASE = 24'h0F_0000;
	localparam int ROM_LSB = 3;
	localparam logic [ADR_W-1:0] IO_ADDR = 24'h00_0080;
	localparam logic [INT_W-1:0] INT_ONE = 8'h01;

	typedef enum logic [1:0] {
		CMD_MRD = 2'b00,
		CMD_MWR = 2'b01,
		CMD_IORD = 2'b10,
		CMD_IOWR = 2'b11
	} cmd_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_ARB = 3'b001,
		M_SETUP = 3'b010,
		M_CMD = 3'b011,
		M_REL = 3'b100
	} mst_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_DATA = 2'b01,
		S_ACK = 2'b10
	} slv_t;

	function automatic int cmd_line(cmd_t c);
		case (c)
			CMD_MRD: cmd_line = C_MRDC;
			CMD_MWR: cmd_line = C_MWTC;
			CMD_IORD: cmd_line = C_IORC;
			default: cmd_line = C_IOWC;
		endcase
	endfunction : cmd_line

	// ROM contents are arbitrary fill
	function automatic logic [DAT_W-1:0] rom_word(logic [1:0] i);
		case (i)
			2'h0: rom_word = 16'h1234;
			2'h1: rom_word = 16'h5678;
			2'h2: rom_word = 16'h9ABC;
			default: rom_word = 16'hDEF0;
		endcase
	endfunction : rom_word
endpackage : bus_pkg

// file: bus_if.sv
// Backplane bus wires with open-collector resolution
`timescale 1ns/1ns
interface bus_if (input wire logic bclk);
	import bus_pkg::*;
	logic [CTL_W-1:0] ctl_dev_o, ctl_dev_oe_n, ctl_host_o, ctl_host_oe_n, ctl;
	logic [ADR_W-1:0] adr_dev_o, adr_dev_oe_n, adr_host_o, adr_host_oe_n, adr;
	logic [DAT_W-1:0] dat_dev_o, dat_dev_oe_n, dat_host_o, dat_host_oe_n, dat;
	logic [INT_W-1:0] int_o, int_oe_n, int_n;
	logic host_bpro_n, dev_bpro_n, dev_breq_n;

	// Undriven lines float high
	assign ctl = (ctl_dev_o | ctl_dev_oe_n) & (ctl_host_o | ctl_host_oe_n);
	assign adr = (adr_dev_o | adr_dev_oe_n) & (adr_host_o | adr_host_oe_n);
	assign dat = (dat_dev_o | dat_dev_oe_n) & (dat_host_o | dat_host_oe_n);
	assign int_n = int_o | int_oe_n;

	modport dev (input bclk, ctl, adr, dat, host_bpro_n,
		output ctl_dev_o, ctl_dev_oe_n, adr_dev_o, adr_dev_oe_n, dat_dev_o, dat_dev_oe_n,
		output int_o, int_oe_n, dev_bpro_n, dev_breq_n);
	modport host (input bclk, ctl, adr, dat, int_n, dev_breq_n,
		output ctl_host_o, ctl_host_oe_n, adr_host_o, adr_host_oe_n, dat_host_o,
		output dat_host_oe_n, host_bpro_n);
endinterface : bus_if

// file: bus_dev.sv
// Device end: bus master, RAM/ROM/IO slave and interrupter
// How it works
// - Low priority-in grants, sampled on bus clock
// - Priority-out feeds next lower master
// - Busy held across transfer; wait while busy
// - Bus request asserted while bus needed; here it is released once the bus is won
// - Memory read places addressed word on data
// - Memory write stores data at address
// - I/O read drives port value on data
// - I/O write loads port from data
// - Acknowledge only after data placed or taken
// - RAM inhibit silences dual-port RAM on bus
// - ROM inhibit silences ROM response
// - Lock held with busy for one transfer, reported
// - Byte-high enable opens odd byte bank
// - Twenty address lines; bit 0 picks even
// - Four extra lines give 24-bit address
// - One jumper-chosen interrupt line of eight
// - Sixteen data lines, even low odd high
`timescale 1ns/1ns
module bus_dev
	import bus_pkg::*;
(
	// Bus link
	bus_if.dev bus,
	// System
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Board straps
	input wire logic [LVL_W-1:0] interrupt_level_jumper,
	// Master request
	input wire logic req,
	input wire bus_pkg::cmd_t cmd,
	input wire logic [ADR_W-1:0] addr,
	input wire logic [DAT_W-1:0] wdata,
	input wire logic lock_req,
	output logic req_busy,
	output logic done,
	output logic [DAT_W-1:0] rdata,
	// Interrupt and status
	input wire logic irq_raise,
	output logic lock_seen
);
	import bus_pkg::*;

	typedef struct packed {
		logic en_s1, en_s2, req_s1, req_s2, req_seen, ack_t;
		logic irq_s1, irq_s2;
		logic [LVL_W-1:0] jmp_s1, jmp_s2;
		mst_t mst;
		slv_t slv;
		logic [CTL_W-1:0] ctl_oe_n;
		logic [ADR_W-1:0] adr_o;
		logic adr_oe_n;
		logic [DAT_W-1:0] dat_o;
		logic dat_oe_n;
		logic bpro_n, breq_n;
		logic [INT_W-1:0] int_oe_n;
		logic [DAT_W-1:0] rdata;
		logic [RAM_WORDS-1:0][DAT_W-1:0] ram;
		logic [DAT_W-1:0] io_q;
		logic lock_q;
	} link_t;

	typedef struct packed {
		logic req_t, ack_s1, ack_s2, ack_seen, busy, done;
		logic [DAT_W-1:0] rdata;
		logic lock_s1, lock_s2, lock_seen;
	} sys_t;

	link_t l_q, l_d;
	sys_t s_q, s_d;

	// Bus levels seen as asserted-high
	logic [CTL_W-1:0] ca;
	logic [ADR_W-1:0] aa;
	logic [DAT_W-1:0] da;
	logic prn_ok, bus_free, new_req, mem_cmd, io_cmd, rd_cmd, any_cmd;
	logic sel_ram, sel_rom, sel_io, sel;
	logic [3:0] widx;
	logic [DAT_W-1:0] rd_val;

	assign ca = ~bus.ctl;
	assign aa = ~bus.adr;
	assign da = ~bus.dat;
	assign prn_ok = ~bus.host_bpro_n;
	assign bus_free = ~ca[C_BUSY];
	assign new_req = l_q.req_s2 != l_q.req_seen;
	assign mem_cmd = ca[C_MRDC] | ca[C_MWTC];
	assign io_cmd = ca[C_IORC] | ca[C_IOWC];
	assign rd_cmd = ca[C_MRDC] | ca[C_IORC];
	assign any_cmd = mem_cmd | io_cmd;
	assign sel_ram = ca[C_MRDC] | ca[C_MWTC] ? (aa[ADR_W-1:RAM_LSB] == RAM_BASE[ADR_W-1:RAM_LSB])
		&& !ca[C_INH1] : 1'b0;
	assign sel_rom = ca[C_MRDC] && (aa[ADR_W-1:ROM_LSB] == ROM_BASE[ADR_W-1:ROM_LSB])
		&& !ca[C_INH2];
	assign sel_io = io_cmd && (aa == IO_ADDR);
	// Own transfers are not answered by own slave
	assign sel = (sel_ram | sel_rom | sel_io) && (l_q.mst == M_IDLE || l_q.mst == M_ARB);
	assign widx = aa[RAM_LSB-1:1];
	assign rd_val = sel_ram ? l_q.ram[widx] : (sel_rom ? rom_word(aa[2:1]) : l_q.io_q);

	////////////////////////////////////////////////////////////////////////////////
	// Link side, bus clock
	always_comb begin
		l_d = l_q;
		l_d.en_s1 = clk_en;
		l_d.en_s2 = l_q.en_s1;
		if (l_q.en_s2) begin
			l_d.req_s1 = s_q.req_t;
			l_d.req_s2 = l_q.req_s1;
			l_d.irq_s1 = irq_raise;
			l_d.irq_s2 = l_q.irq_s1;
			l_d.jmp_s1 = interrupt_level_jumper;
			l_d.jmp_s2 = l_q.jmp_s1;
			l_d.int_oe_n = l_q.irq_s2 ? ~(INT_ONE << l_q.jmp_s2) : '1;
			l_d.lock_q = ca[C_LOCK] && any_cmd;
			// Pass priority down only when idle and granted
			l_d.bpro_n = !(prn_ok && l_q.mst == M_IDLE && !new_req);
			case (l_q.mst)
				M_IDLE: begin
					if (new_req) begin
						l_d.req_seen = l_q.req_s2;
						l_d.breq_n = 1'b0;
						l_d.mst = M_ARB;
					end
				end
				M_ARB: begin
					if (prn_ok && bus_free) begin
						l_d.breq_n = 1'b1;
						l_d.ctl_oe_n[C_BUSY] = 1'b0;
						l_d.ctl_oe_n[C_LOCK] = !lock_req;
						l_d.ctl_oe_n[C_BHEN] = !(addr[0] || cmd[1] == 1'b0);
						l_d.adr_o = ~addr;
						l_d.adr_oe_n = 1'b0;
						l_d.dat_o = ~wdata;
						l_d.dat_oe_n = !cmd[0];
						l_d.mst = M_SETUP;
					end
				end
				M_SETUP: begin
					l_d.ctl_oe_n[cmd_line(cmd)] = 1'b0;
					l_d.mst = M_CMD;
				end
				M_CMD: begin
					if (ca[C_XACK]) begin
						l_d.rdata = da;
						l_d.ctl_oe_n[cmd_line(cmd)] = 1'b1;
						l_d.dat_oe_n = 1'b1;
						l_d.mst = M_REL;
					end
				end
				M_REL: begin
					if (!ca[C_XACK]) begin
						l_d.ctl_oe_n[C_BUSY] = 1'b1;
						l_d.ctl_oe_n[C_LOCK] = 1'b1;
						l_d.ctl_oe_n[C_BHEN] = 1'b1;
						l_d.adr_oe_n = 1'b1;
						l_d.ack_t = !l_q.ack_t;
						l_d.mst = M_IDLE;
					end
				end
				default: l_d.mst = M_IDLE;
			endcase
			case (l_q.slv)
				S_IDLE: begin
					if (sel) begin
						if (rd_cmd) begin
							l_d.dat_o = ~rd_val;
							l_d.dat_oe_n = 1'b0;
						end else if (sel_ram) begin
							if (!aa[0])
								l_d.ram[widx][7:0] = da[7:0];
							if (ca[C_BHEN])
								l_d.ram[widx][15:8] = da[15:8];
						end else begin
							l_d.io_q = da;
						end
						l_d.slv = S_DATA;
					end
				end
				S_DATA: begin
					l_d.ctl_oe_n[C_XACK] = 1'b0;
					l_d.slv = S_ACK;
				end
				S_ACK: begin
					if (!any_cmd) begin
						l_d.ctl_oe_n[C_XACK] = 1'b1;
						l_d.dat_oe_n = 1'b1;
						l_d.slv = S_IDLE;
					end
				end
				default: l_d.slv = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge bus.bclk or negedge nrst) begin
		if (!nrst) begin
			l_q <= '0;
			l_q.ctl_oe_n <= '1;
			l_q.adr_oe_n <= 1'b1;
			l_q.dat_oe_n <= 1'b1;
			l_q.bpro_n <= 1'b1;
			l_q.breq_n <= 1'b1;
			l_q.int_oe_n <= '1;
		end else begin
			l_q <= l_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// User side, system clock
	always_comb begin
		s_d = s_q;
		if (clk_en) begin
			s_d.ack_s1 = l_q.ack_t;
			s_d.ack_s2 = s_q.ack_s1;
			s_d.lock_s1 = l_q.lock_q;
			s_d.lock_s2 = s_q.lock_s1;
			s_d.lock_seen = s_q.lock_s2;
			s_d.done = 1'b0;
			if (req && !s_q.busy) begin
				s_d.req_t = !s_q.req_t;
				s_d.busy = 1'b1;
			end
			if (s_q.ack_s2 != s_q.ack_seen) begin
				s_d.ack_seen = s_q.ack_s2;
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.rdata = l_q.rdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign req_busy = s_q.busy;
	assign done = s_q.done;
	assign rdata = s_q.rdata;
	assign lock_seen = s_q.lock_seen;
	assign bus.ctl_dev_o = '0;
	assign bus.ctl_dev_oe_n = l_q.ctl_oe_n;
	assign bus.adr_dev_o = l_q.adr_o;
	assign bus.adr_dev_oe_n = {ADR_W{l_q.adr_oe_n}};
	assign bus.dat_dev_o = l_q.dat_o;
	assign bus.dat_dev_oe_n = {DAT_W{l_q.dat_oe_n}};
	assign bus.int_o = '0;
	assign bus.int_oe_n = l_q.int_oe_n;
	assign bus.dev_bpro_n = l_q.bpro_n;
	assign bus.dev_breq_n = l_q.breq_n;
endmodule : bus_dev

// file: bus_host.sv
// Host end: highest-priority bus master and interrupt receiver
`timescale 1ns/1ns
module bus_host
	import bus_pkg::*;
(
	// Bus link
	bus_if.host bus,
	// System
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Master request
	input wire logic req,
	input wire bus_pkg::cmd_t cmd,
	input wire logic [ADR_W-1:0] addr,
	input wire logic [DAT_W-1:0] wdata,
	input wire logic lock_req,
	output logic req_busy,
	output logic done,
	output logic [DAT_W-1:0] rdata,
	// Overlay controls
	input wire logic inhibit_ram,
	input wire logic inhibit_rom,
	// Status
	output logic [INT_W-1:0] irq,
	output logic dev_wants_bus
);
	import bus_pkg::*;

	typedef struct packed {
		logic en_s1, en_s2, req_s1, req_s2, req_seen, ack_t;
		logic inh1_s1, inh1_s2, inh2_s1, inh2_s2;
		mst_t mst;
		logic [CTL_W-1:0] ctl_oe_n;
		logic [ADR_W-1:0] adr_o;
		logic adr_oe_n;
		logic [DAT_W-1:0] dat_o;
		logic dat_oe_n;
		logic bpro_n;
		logic [DAT_W-1:0] rdata;
	} link_t;

	typedef struct packed {
		logic req_t, ack_s1, ack_s2, ack_seen, busy, done;
		logic [DAT_W-1:0] rdata;
		logic [INT_W-1:0] int_s1, int_s2;
		logic breq_s1, breq_s2;
	} sys_t;

	link_t l_q, l_d;
	sys_t s_q, s_d;
	logic [CTL_W-1:0] ca;
	logic new_req;

	assign ca = ~bus.ctl;
	assign new_req = l_q.req_s2 != l_q.req_seen;

	////////////////////////////////////////////////////////////////////////////////
	// Link side, bus clock
	always_comb begin
		l_d = l_q;
		l_d.en_s1 = clk_en;
		l_d.en_s2 = l_q.en_s1;
		if (l_q.en_s2) begin
			l_d.req_s1 = s_q.req_t;
			l_d.req_s2 = l_q.req_s1;
			l_d.inh1_s1 = inhibit_ram;
			l_d.inh1_s2 = l_q.inh1_s1;
			l_d.inh2_s1 = inhibit_rom;
			l_d.inh2_s2 = l_q.inh2_s1;
			l_d.ctl_oe_n[C_INH1] = !l_q.inh1_s2;
			l_d.ctl_oe_n[C_INH2] = !l_q.inh2_s2;
			// Head of chain: priority withheld while wanting or holding the bus
			l_d.bpro_n = !(l_q.mst == M_IDLE && !new_req);
			case (l_q.mst)
				M_IDLE: begin
					if (new_req) begin
						l_d.req_seen = l_q.req_s2;
						l_d.mst = M_ARB;
					end
				end
				M_ARB: begin
					if (!ca[C_BUSY]) begin
						l_d.ctl_oe_n[C_BUSY] = 1'b0;
						l_d.ctl_oe_n[C_LOCK] = !lock_req;
						l_d.ctl_oe_n[C_BHEN] = !(addr[0] || cmd[1] == 1'b0);
						l_d.adr_o = ~addr;
						l_d.adr_oe_n = 1'b0;
						l_d.dat_o = ~wdata;
						l_d.dat_oe_n = !cmd[0];
						l_d.mst = M_SETUP;
					end
				end
				M_SETUP: begin
					l_d.ctl_oe_n[cmd_line(cmd)] = 1'b0;
					l_d.mst = M_CMD;
				end
				M_CMD: begin
					if (ca[C_XACK]) begin
						l_d.rdata = ~bus.dat;
						l_d.ctl_oe_n[cmd_line(cmd)] = 1'b1;
						l_d.dat_oe_n = 1'b1;
						l_d.mst = M_REL;
					end
				end
				M_REL: begin
					if (!ca[C_XACK]) begin
						l_d.ctl_oe_n[C_BUSY] = 1'b1;
						l_d.ctl_oe_n[C_LOCK] = 1'b1;
						l_d.ctl_oe_n[C_BHEN] = 1'b1;
						l_d.adr_oe_n = 1'b1;
						l_d.ack_t = !l_q.ack_t;
						l_d.mst = M_IDLE;
					end
				end
				default: l_d.mst = M_IDLE;
			endcase
		end
	end

	always_ff @(posedge bus.bclk or negedge nrst) begin
		if (!nrst) begin
			l_q <= '0;
			l_q.ctl_oe_n <= '1;
			l_q.adr_oe_n <= 1'b1;
			l_q.dat_oe_n <= 1'b1;
			l_q.bpro_n <= 1'b1;
		end else begin
			l_q <= l_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// User side, system clock
	always_comb begin
		s_d = s_q;
		if (clk_en) begin
			s_d.ack_s1 = l_q.ack_t;
			s_d.ack_s2 = s_q.ack_s1;
			s_d.int_s1 = ~bus.int_n;
			s_d.int_s2 = s_q.int_s1;
			s_d.breq_s1 = ~bus.dev_breq_n;
			s_d.breq_s2 = s_q.breq_s1;
			s_d.done = 1'b0;
			if (req && !s_q.busy) begin
				s_d.req_t = !s_q.req_t;
				s_d.busy = 1'b1;
			end
			if (s_q.ack_s2 != s_q.ack_seen) begin
				s_d.ack_seen = s_q.ack_s2;
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.rdata = l_q.rdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign req_busy = s_q.busy;
	assign done = s_q.done;
	assign rdata = s_q.rdata;
	assign irq = s_q.int_s2;
	assign dev_wants_bus = s_q.breq_s2;
	assign bus.ctl_host_o = '0;
	assign bus.ctl_host_oe_n = l_q.ctl_oe_n;
	assign bus.adr_host_o = l_q.adr_o;
	assign bus.adr_host_oe_n = {ADR_W{l_q.adr_oe_n}};
	assign bus.dat_host_o = l_q.dat_o;
	assign bus.dat_host_oe_n = {DAT_W{l_q.dat_oe_n}};
	assign bus.host_bpro_n = l_q.bpro_n;
endmodule : bus_host

// file: backplane_bus_asserts.sv
// Concurrent checks on the backplane bus wires
`timescale 1ns/1ns
module backplane_bus_asserts
	import bus_pkg::*;
(
	// Clock and reset
	input wire logic bclk,
	input wire logic nrst,
	// Resolved lines
	input wire logic [CTL_W-1:0] ctl,
	input wire logic [ADR_W-1:0] adr,
	// Device drives
	input wire logic [CTL_W-1:0] ctl_dev_oe_n,
	input wire logic [DAT_W-1:0] dat_dev_oe_n,
	input wire logic [INT_W-1:0] int_oe_n,
	// Arbitration
	input wire logic host_bpro_n,
	input wire logic dev_bpro_n,
	input wire logic dev_breq_n
);
	default clocking @(posedge bclk); endclocking
	default disable iff (!nrst);
	logic [ADR_W-1:0] wire_addr;
	logic dev_cmd;
	// Address lines are inverted on the wire
	assign wire_addr = ~adr;
	assign dev_cmd = ctl_dev_oe_n[C_IOWC:C_MRDC] != 4'hF;
	////////////////////////////////////////////////////////////////////////
	a_grant_on_prio: assert property ($fell(ctl_dev_oe_n[C_BUSY]) |->
		!$past(host_bpro_n) && $past(ctl[C_BUSY])) else $error("bus taken without grant");
	a_request_before_grant: assert property ($fell(ctl_dev_oe_n[C_BUSY]) |->
		!$past(dev_breq_n)) else $error("bus taken without request");
	a_busy_over_cmd: assert property (dev_cmd |-> !ctl_dev_oe_n[C_BUSY])
		else $error("command without busy");
	a_ack_after_data: assert property ($fell(ctl_dev_oe_n[C_XACK]) &&
		(!ctl[C_MRDC] || !ctl[C_IORC]) |-> $past(dat_dev_oe_n) != 16'hFFFF)
		else $error("read acknowledged before data");
	a_ack_released: assert property ($rose(ctl[C_MRDC]) |-> ##[1:3] ctl_dev_oe_n[C_XACK])
		else $error("acknowledge held after command");
	a_ram_inhibit: assert property (!ctl[C_INH1] &&
		wire_addr[ADR_W-1:RAM_LSB] == RAM_BASE[ADR_W-1:RAM_LSB] |-> ctl_dev_oe_n[C_XACK])
		else $error("inhibited ram answered");
	a_rom_inhibit: assert property (!ctl[C_INH2] &&
		wire_addr[ADR_W-1:ROM_LSB] == ROM_BASE[ADR_W-1:ROM_LSB] |-> ctl_dev_oe_n[C_XACK])
		else $error("inhibited rom answered");
	a_one_int_line: assert property ($onehot0(~int_oe_n))
		else $error("more than one interrupt line");
	a_prio_passes_down: assert property (host_bpro_n[*3] |-> dev_bpro_n)
		else $error("priority passed without grant");
	cover property ($fell(ctl_dev_oe_n[C_BUSY]));
	cover property ($fell(ctl_dev_oe_n[C_XACK]));
	cover property (int_oe_n != 8'hFF);
endmodule : backplane_bus_asserts

// file: test_backplane_bus_master_slave_port.sv
// Self-checking bench joining host and device ends
`timescale 1ns/1ns
module test_backplane_bus_master_slave_port;
	import bus_pkg::*;
	localparam logic [DAT_W-1:0] ROM_EXP [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
	logic sys_clk, bclk, nrst, inhibit_ram, inhibit_rom, irq_raise, lock_seen, dev_wants_bus;
	logic clk_en;
	logic lock_hit, want_hit;
	logic [LVL_W-1:0] interrupt_level_jumper;
	logic [INT_W-1:0] irq;
	logic req[2], lk[2], req_busy[2], done[2];
	cmd_t cmd[2];
	logic [ADR_W-1:0] addr[2];
	logic [DAT_W-1:0] wdata[2], rdata[2], got;
	int err_count, checks_done;

	bus_if bus_if_i (.bclk(bclk));
	bus_host bus_host_i (.bus(bus_if_i), .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
		.req(req[0]), .cmd(cmd[0]), .addr(addr[0]), .wdata(wdata[0]), .lock_req(lk[0]),
		.req_busy(req_busy[0]), .done(done[0]), .rdata(rdata[0]), .inhibit_ram(inhibit_ram),
		.inhibit_rom(inhibit_rom), .irq(irq), .dev_wants_bus(dev_wants_bus));
	bus_dev bus_dev_i (.bus(bus_if_i), .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
		.interrupt_level_jumper(interrupt_level_jumper), .req(req[1]), .cmd(cmd[1]),
		.addr(addr[1]), .wdata(wdata[1]), .lock_req(lk[1]), .req_busy(req_busy[1]),
		.done(done[1]), .rdata(rdata[1]), .irq_raise(irq_raise), .lock_seen(lock_seen));
	backplane_bus_asserts backplane_bus_asserts_i (.bclk(bclk), .nrst(nrst),
		.ctl(bus_if_i.ctl), .adr(bus_if_i.adr), .ctl_dev_oe_n(bus_if_i.ctl_dev_oe_n),
		.dat_dev_oe_n(bus_if_i.dat_dev_oe_n), .int_oe_n(bus_if_i.int_oe_n),
		.host_bpro_n(bus_if_i.host_bpro_n), .dev_bpro_n(bus_if_i.dev_bpro_n),
		.dev_breq_n(bus_if_i.dev_breq_n));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		bclk = 1'b0;
		forever begin
			#7 bclk = 1'b1;
			#8 bclk = 1'b0;
		end
	end
	// Sticky flags for short status levels
	always @(posedge sys_clk) begin
		if (lock_seen === 1'b1) lock_hit <= 1'b1;
		if (dev_wants_bus === 1'b1) want_hit <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [DAT_W-1:0] exp,
		input logic [DAT_W-1:0] seen);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	// One command from end w; want_done says whether it may complete
	task automatic xfer(input int w, input cmd_t c, input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] d, input logic l, input logic want_done);
		int n;
		n = 0;
		@(posedge sys_clk);
		#2;
		req[w] = 1'b1;
		cmd[w] = c;
		addr[w] = a;
		wdata[w] = d;
		lk[w] = l;
		@(posedge sys_clk);
		#2;
		req[w] = 1'b0;
		chk("request busy", 16'h1, {15'h0, req_busy[w]});
		while (done[w] !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			#2;
			n++;
		end
		got = rdata[w];
		chk("completion", {15'h0, want_done}, {15'h0, n < 300});
	endtask : xfer

	task automatic do_reset;
		nrst = 1'b0;
		inhibit_ram = 1'b0;
		inhibit_rom = 1'b0;
		repeat (12) @(posedge sys_clk);
		#2;
		nrst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#2;
	endtask : do_reset

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		irq_raise = 1'b0;
		interrupt_level_jumper = 3'h0;
		clk_en = 1'b1;
		lock_hit = 1'b0;
		want_hit = 1'b0;
		err_count = 0;
		checks_done = 0;
		foreach (req[i]) begin
			req[i] = 1'b0;
			lk[i] = 1'b0;
			cmd[i] = CMD_MRD;
			addr[i] = 24'h0;
			wdata[i] = 16'h0;
		end
		do_reset();
		xfer(0, CMD_MWR, RAM_BASE + 24'h4, 16'hAAAA, 1'b0, 1'b1);
		xfer(0, CMD_MWR, RAM_BASE + 24'h5, 16'h1234, 1'b1, 1'b1);
		xfer(0, CMD_MRD, RAM_BASE + 24'h4, 16'h0, 1'b0, 1'b1);
		chk("ram word", 16'h12AA, got);
		chk("lock seen", 16'h1, {15'h0, lock_hit});
		$display("test ram done");
		for (int i = 0; i < 4; i++) begin
			xfer(0, CMD_MRD, ROM_BASE + 24'(2 * i), 16'h0, 1'b0, 1'b1);
			chk("rom word", ROM_EXP[i], got);
		end
		$display("test rom done");
		xfer(0, CMD_IOWR, IO_ADDR, 16'h5AC3, 1'b0, 1'b1);
		xfer(0, CMD_IORD, IO_ADDR, 16'h0, 1'b0, 1'b1);
		chk("io port", 16'h5AC3, got);
		$display("test io done");
		for (int k = 0; k < 8; k++) begin
			interrupt_level_jumper = 3'(k);
			repeat (4) @(posedge sys_clk);
			#2;
			irq_raise = 1'b1;
			repeat (12) @(posedge sys_clk);
			#2;
			chk("irq line", 16'(INT_ONE << k), 16'(irq));
			irq_raise = 1'b0;
			repeat (12) @(posedge sys_clk);
			#2;
			chk("irq clear", 16'h0, 16'(irq));
		end
		// Clock enable low freezes both ends, so the raise stays unseen
		clk_en = 1'b0;
		irq_raise = 1'b1;
		repeat (12) @(posedge sys_clk);
		#2;
		chk("irq frozen", 16'h0, 16'(irq));
		clk_en = 1'b1;
		repeat (12) @(posedge sys_clk);
		#2;
		chk("irq thawed", 16'(INT_ONE << 7), 16'(irq));
		irq_raise = 1'b0;
		repeat (12) @(posedge sys_clk);
		#2;
		$display("test interrupt done");
		for (int t = 0; t < 2; t++) begin
			inhibit_ram = (t == 0);
			inhibit_rom = (t == 1);
			xfer(0, CMD_MRD, t == 0 ? RAM_BASE : ROM_BASE, 16'h0, 1'b0, 1'b0);
			do_reset();
		end
		$display("test inhibit done");
		xfer(0, CMD_MRD, RAM_BASE | 24'h10_0000, 16'h0, 1'b0, 1'b0);
		xfer(1, CMD_MWR, RAM_BASE, 16'h0F0F, 1'b1, 1'b0);
		chk("request seen", 16'h1, {15'h0, want_hit});
		do_reset();
		// Device wins a free bus; its own slave must not answer it
		xfer(1, CMD_MWR, RAM_BASE, 16'h0F0F, 1'b1, 1'b0);
		chk("device rdata", 16'h0, rdata[1]);
		do_reset();
		$display("test arbitration done");
		complete_run();
	end

	initial begin
		// Tests take about 2000 cycles, mostly the deliberate hangs
		repeat (6000) @(posedge sys_clk);
		err_count++;
		complete_run();
	end
endmodule : test_backplane_bus_master_slave_port
